//--- src/alu_exec.sv
/*
  Add/AND execution datapath with accumulator, status flags and file
  registers, driven by instruction words written over APB.
  Assumes an APB master on clk; port pins come from outside the clock.
*/
// The register offsets and the APB slave port were decided locally.
// Overview of operation
// [RL1] Add-immediate: acc plus literal, flags C DC Z
// [RL2] AND-immediate: acc and literal, zero flag only
// [RL3] Add-file: acc plus file register, C DC Z
// [RL4] Destination bit picks accumulator or file register
// [RL5] AND-file: acc and file register, zero only
// [RL6] Instruction reads of the port register use live pin levels
// [RL7] Z on zero, C bit7 carry, DC bit3
`timescale 1ns/1ns
`include "alu_exec_defs.svh"
module alu_exec
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port pins
  input wire logic [7:0] portPins,
  // Busy and accumulator copy
  output logic busy,
  output logic [7:0] accOut
);
  import alu_exec_pkg::*;

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic [1:0] rstSync_q;
  logic rstSyncB;

  // Two stages so release is glitch-free across the whole block
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rstSync_q <= 2'b00;
    end
    else
    begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstSyncB = rstSync_q[1];

  // ---------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------
  logic [7:0] pin1_q, pin2_q, pin3_q, pinLvl_q;
  logic [7:0] pinLvl_d;

  // Level accepted once stages two and three agree
  always_comb
  begin
    pinLvl_d = pinLvl_q;
    for (int i = 0; i < 8; i++)
    begin
      if (pin2_q[i] == pin3_q[i])
        pinLvl_d[i] = pin3_q[i];
    end
  end

  always_ff @(posedge clk or negedge rstSyncB)
  begin
    if (!rstSyncB)
    begin
      pin1_q <= 8'h00;
      pin2_q <= 8'h00;
      pin3_q <= 8'h00;
      pinLvl_q <= 8'h00;
    end
    else
    begin
      pin1_q <= portPins;
      pin2_q <= pin1_q;
      pin3_q <= pin2_q;
      pinLvl_q <= pinLvl_d;
    end
  end

  // ---------------------------------------------------------------
  // Decode and arithmetic helpers
  // ---------------------------------------------------------------
  function automatic op_kind_t decode(input instr_t iw);
    if ((iw & `OP_ADD_IMM_MASK) == `OP_ADD_IMM_VAL)
      return OP_ADD_IMM; // [RL1]
    else if ((iw & `OP_AND_IMM_MASK) == `OP_AND_IMM_VAL)
      return OP_AND_IMM; // [RL2]
    else if ((iw & `OP_FILE_MASK) == `OP_ADD_FILE_VAL)
      return OP_ADD_FILE; // [RL3]
    else if ((iw & `OP_FILE_MASK) == `OP_AND_FILE_VAL)
      return OP_AND_FILE; // [RL5]
    else
      return OP_NONE;
  endfunction

  // Sum with carry out of bit 7 and bit 3
  function automatic logic [9:0] add8(input byte_t a, input byte_t b);
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, a} + {1'b0, b};
    low = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    return {low[4], full}; // [RL7]
  endfunction

  // ---------------------------------------------------------------
  // Execution state
  // ---------------------------------------------------------------
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_EXEC = 2'b10
  } state_t;

  state_t state_q, state_d;
  instr_t instr_q, instr_d;
  byte_t acc_q, acc_d;
  logic [2:0] status_q, status_d;
  logic fileWr;
  logic [6:0] fileWrAddr, fileRdAddr;
  byte_t fileWrData, fileRd, operand;
  logic [9:0] sum;
  byte_t res;
  op_kind_t kind;
  logic apbWr, apbRd, inFile;
  logic [31:0] prdata_d;
  logic pslverr_d, pready_d, readArm_q, readArm_d;

  assign apbWr = psel && penable && pwrite && pready;
  assign apbRd = psel && !pwrite;
  assign inFile = (paddr >= `REG_FILE_BASE) && (paddr <= `REG_FILE_LAST);
  assign kind = decode(instr_q);

  // Live pins replace the port latch as a source
  assign operand = (instr_q[`ADDR_MSB:0] == `PORT_ADDR) ?
    pinLvl_q : fileRd; // [RL6]

  // Datapath: one instruction per word, result in ST_EXEC
  always_comb
  begin
    state_d = state_q;
    instr_d = instr_q;
    acc_d = acc_q;
    status_d = status_q;
    fileWr = 1'b0;
    fileWrAddr = paddr[8:2];
    fileWrData = pwdata[7:0];
    fileRdAddr = instr_q[`ADDR_MSB:0];
    sum = 10'h000;
    res = 8'h00;
    unique case (state_q)
      ST_IDLE:
      begin
        if (apbWr && inFile)
          fileWr = 1'b1;
        else if (apbWr && paddr == `REG_ACC)
          acc_d = pwdata[7:0];
        else if (apbWr && paddr == `REG_STATUS)
          status_d = pwdata[2:0];
        else if (apbWr && paddr == `REG_INSTR)
        begin
          instr_d = pwdata[13:0];
          state_d = ST_READ;
        end
      end
      ST_READ:
        // RAM read is registered, so one cycle to fetch the operand
        state_d = ST_EXEC;
      ST_EXEC:
      begin
        state_d = ST_IDLE;
        unique case (kind)
          OP_ADD_IMM, OP_ADD_FILE:
          begin
            sum = add8(acc_q, (kind == OP_ADD_IMM) ?
              instr_q[7:0] : operand); // [RL1] [RL3]
            res = sum[7:0];
            status_d[`FLAG_CARRY] = sum[8]; // [RL7]
            status_d[`FLAG_HALF] = sum[9]; // [RL7]
            status_d[`FLAG_ZERO] = (res == 8'h00); // [RL7]
          end
          OP_AND_IMM, OP_AND_FILE:
          begin
            res = acc_q & ((kind == OP_AND_IMM) ?
              instr_q[7:0] : operand); // [RL2] [RL5]
            status_d[`FLAG_ZERO] = (res == 8'h00); // [RL7]
          end
          OP_NONE:
            res = acc_q;
        endcase
        if (kind == OP_ADD_IMM || kind == OP_AND_IMM)
          acc_d = res; // [RL1] [RL2]
        else if (kind != OP_NONE)
        begin
          if (instr_q[`DEST_BIT])
          begin
            fileWr = 1'b1; // [RL4]
            fileWrAddr = instr_q[`ADDR_MSB:0];
            fileWrData = res;
          end
          else
            acc_d = res; // [RL4]
        end
      end
      default:
        state_d = ST_IDLE;
    endcase
    // Bus reads own the RAM address only while no instruction runs
    if (state_q == ST_IDLE && apbRd && inFile)
      fileRdAddr = paddr[8:2];
  end

  // APB answer: one wait state so file reads come out of the RAM;
  // the armed cycle puts paddr on the RAM before the answer is made
  always_comb
  begin
    readArm_d = psel && !pready && (state_q == ST_IDLE);
    pready_d = readArm_d && readArm_q;
    pslverr_d = 1'b0;
    prdata_d = prdata;
    if (pready_d)
    begin
      prdata_d = 32'h0000_0000;
      if (paddr == `REG_ACC)
        prdata_d = {24'h00_0000, acc_q};
      else if (paddr == `REG_STATUS)
        prdata_d = {29'h0000_0000, status_q};
      else if (paddr == `REG_INSTR)
        prdata_d = {18'h0_0000, instr_q};
      else if (inFile)
        prdata_d = {24'h00_0000, fileRd};
      else
        pslverr_d = 1'b1;
    end
  end

  file_ram #(
    .DEPTH(`FILE_DEPTH),
    .AW(7)
  ) u_ram (
    .clk(clk),
    .rstSyncB(rstSyncB),
    .wrEn(fileWr),
    .wrAddr(fileWrAddr),
    .wrData(fileWrData),
    .rdAddr(fileRdAddr),
    .rdData(fileRd)
  );

  // State registers
  always_ff @(posedge clk or negedge rstSyncB)
  begin
    if (!rstSyncB)
    begin
      state_q <= ST_IDLE;
      instr_q <= 14'h0000;
      acc_q <= `ACC_RESET;
      status_q <= `STATUS_RESET;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      readArm_q <= 1'b0;
      busy <= 1'b0;
      accOut <= `ACC_RESET;
    end
    else
    begin
      state_q <= state_d;
      instr_q <= instr_d;
      acc_q <= acc_d;
      status_q <= status_d;
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
      readArm_q <= readArm_d;
      busy <= (state_d != ST_IDLE);
      accOut <= acc_d;
    end
  end
endmodule

//--- src/alu_exec_defs.svh
/*
  Constants for the add/AND execution block: opcode patterns, field
  positions, reset values and the APB register map.
  Assumes inclusion by bare name from the package and the modules.
*/
`ifndef ALU_EXEC_DEFS_SVH
`define ALU_EXEC_DEFS_SVH

// Opcode fields of a 14-bit instruction word
`define OP_ADD_IMM_MASK 14'h3E00
`define OP_ADD_IMM_VAL 14'h3E00
`define OP_AND_IMM_MASK 14'h3F00
`define OP_AND_IMM_VAL 14'h3900
`define OP_FILE_MASK 14'h3F00
`define OP_ADD_FILE_VAL 14'h0700
`define OP_AND_FILE_VAL 14'h0500
`define DEST_BIT 7
`define ADDR_MSB 6

// Status flag positions
`define FLAG_CARRY 0
`define FLAG_HALF 1
`define FLAG_ZERO 2

// Reset values
`define ACC_RESET 8'h00
`define STATUS_RESET 3'h0

// APB register byte offsets
`define REG_INSTR 12'h000
`define REG_ACC 12'h004
`define REG_STATUS 12'h008
`define REG_FILE_BASE 12'h200
`define REG_FILE_LAST 12'h3FC

// Number of file registers and the port-mapped address
`define FILE_DEPTH 128
`define PORT_ADDR 7'h06

`endif

//--- src/alu_exec_pkg.sv
/*
  Types shared by the add/AND execution block.
  Assumes the defs header is on the include path.
*/
package alu_exec_pkg;
  `include "alu_exec_defs.svh"

  // Decoded instruction kinds
  typedef enum logic [2:0]
  {
    OP_NONE = 3'b000,
    OP_ADD_IMM = 3'b001,
    OP_AND_IMM = 3'b010,
    OP_ADD_FILE = 3'b011,
    OP_AND_FILE = 3'b100
  } op_kind_t;

  typedef logic [7:0] byte_t;
  typedef logic [13:0] instr_t;
endpackage

//--- src/file_ram.sv
/*
  File register memory: 128 bytes, one write and one registered read.
  Assumes one clock and an already synchronised active-low reset.
*/
`timescale 1ns/1ns
module file_ram #(
  parameter int DEPTH = 128,
  parameter int AW = 7
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstSyncB,
  // Write port
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [7:0] wrData,
  // Read port
  input wire logic [AW-1:0] rdAddr,
  output logic [7:0] rdData
);
  logic [7:0] mem [DEPTH];
  logic [7:0] rdData_d;

  // Next read word; a same-cycle write is forwarded
  always_comb
  begin
    rdData_d = mem[rdAddr];
    if (wrEn && (wrAddr == rdAddr))
    begin
      rdData_d = wrData;
    end
  end

  // Storage array, no reset so it maps to RAM
  always_ff @(posedge clk)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
  end

  // Registered read data
  always_ff @(posedge clk or negedge rstSyncB)
  begin
    if (!rstSyncB)
    begin
      rdData <= 8'h00;
    end
    else
    begin
      rdData <= rdData_d;
    end
  end
endmodule

//--- sim/alu_exec_assertions.sv
/*
  Port checker for the add/AND execution block.
  Assumes a bind from the bench top; one clock domain.
*/
`timescale 1ns/1ns
module alu_exec_assertions
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // Pins and status
  input wire logic [7:0] portPins,
  input wire logic busy,
  input wire logic [7:0] accOut
);
  // -----------------------------
  // Instruction word accepted
  // -----------------------------
  logic wr;
  assign wr = psel && penable && pready && pwrite && paddr == 12'h000;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Run steps; six edges leave room for the registered copy of acc
  sequence s_run;
    busy [*2] ##1 !busy;
  endsequence
  property p_busy;
    wr |=> s_run;
  endproperty
  a_busy: assert property (p_busy)
    else $error("instruction run length wrong");
  property p_hold;
    busy |-> !pready;
  endproperty
  a_hold: assert property (p_hold)
    else $error("bus answered during a run");
  property p_add_imm;
    logic [7:0] a, k;
    (wr && pwdata[13:9] == 5'h1F, a = accOut, k = pwdata[7:0])
      |-> ##6 accOut == 8'(a + k);
  endproperty
  a_add_imm: assert property (p_add_imm)
    else $error("literal add result wrong");
  property p_and_imm;
    logic [7:0] a, k;
    (wr && pwdata[13:8] == 6'h39, a = accOut, k = pwdata[7:0])
      |-> ##6 accOut == (a & k);
  endproperty
  a_and_imm: assert property (p_and_imm)
    else $error("literal and result wrong");
  property p_to_file;
    logic [7:0] a;
    (wr && pwdata[7] && (pwdata[13:8] == 6'h07 || pwdata[13:8] == 6'h05),
      a = accOut) |-> ##6 accOut == a;
  endproperty
  a_to_file: assert property (p_to_file)
    else $error("acc changed on file destination");
  property p_and_sub;
    logic [7:0] a;
    (wr && pwdata[13:8] == 6'h05 && !pwdata[7], a = accOut)
      |-> ##6 (accOut & ~a) == 8'h00;
  endproperty
  a_and_sub: assert property (p_and_sub)
    else $error("file and set a bit not in acc");
  property p_port;
    logic [7:0] a, p;
    (wr && pwdata[13:0] == 14'h0506, a = accOut, p = portPins)
      |-> ##6 accOut == (a & p);
  endproperty
  a_port: assert property (p_port)
    else $error("port source not taken from pins");
endmodule

//--- sim/tb_top.sv
/*
  Bench for the add/AND block: APB tasks and instruction runs.
  Assumes the design package and header on the include path.
*/
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, busy, er;
  // Pins held still so the synchroniser has long settled
  logic [7:0] portPins = 8'h20;
  logic [7:0] accOut;
  int errors = 0;
  int total_checks = 0;
  always #2 clk = ~clk;
  alu_exec dut (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .portPins(portPins), .busy(busy), .accOut(accOut));
  // -----------------------------
  // Report and compare
  // -----------------------------
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Pready read right after the edge: the value sampled at that edge
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'h1 && n < 40);
    if (pready !== 1'h1)
    begin
      errors++;
      complete_run();
    end
    else
    begin
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask
  // Load acc, run one word, read acc and flags back
  task automatic run(input logic [7:0] a0, input logic [13:0] ins,
    input logic [7:0] ea, input logic [2:0] es);
    apb(1'h1, 12'h004, {24'h0, a0});
    apb(1'h1, 12'h000, {18'h0, ins});
    apb(1'h0, 12'h004, 32'h0);
    chk(rd, {24'h0, ea});
    apb(1'h0, 12'h008, 32'h0);
    chk(rd, {29'h0, es});
  endtask
  // -----------------------------
  // Main sequence
  // -----------------------------
  initial
  begin
    repeat (4) @(posedge clk);
    rst_b <= 1'h1;
    repeat (3) @(posedge clk);
    run(8'h10, 14'h3E15, 8'h25, 3'h0);
    run(8'h25, 14'h3FDB, 8'h00, 3'h7);
    run(8'hA3, 14'h395F, 8'h03, 3'h3);
    apb(1'h1, 12'h210, 32'hC2);
    run(8'h17, 14'h0704, 8'hD9, 3'h0);
    apb(1'h0, 12'h210, 32'h0);
    chk(rd, 32'hC2);
    run(8'h17, 14'h0584, 8'h17, 3'h0);
    apb(1'h0, 12'h210, 32'h0);
    chk(rd, 32'h02);
    // Latch full of ones, pins give the zero result
    apb(1'h1, 12'h218, 32'hFF);
    run(8'hD9, 14'h0506, 8'h00, 3'h4);
    apb(1'h0, 12'h100, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    complete_run();
  end
endmodule
bind alu_exec alu_exec_assertions chk_i (.clk(clk), .rst_b(rst_b),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .portPins(portPins), .busy(busy),
  .accOut(accOut));
